/* File: design/remote_command_frame_handler.v */
// remote command frame handler: frame parser, command dispatch and APB register slave
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "frame_handler_map.vh"

// Overview of operation
// - frame is header, addresses, length, command, params, checksum
// - replies go to 0x70 from 0x01
// - length counts command plus parameter bytes
// - setting commands answer 0x7F with 0x00
// - 0x2A sets lock state 0/1/2
// - 0xAA returns the lock state
// - 0x2C clears steps, restores defaults, acknowledges
// - 0xAD returns defined step count
// - 0x2E selects local, remote or lockout
// - 0xAE returns the control state
// - 0x2F carries index, capacitance, range
// - index 1..10, cap 0..120000, range 1..3
// - capacitance arrives least significant byte first
// - query replies echo their command code
module remote_command_frame_handler (
    input wire i_clock,
    input wire i_rst_n,
    // byte stream from the link
    input wire i_rx_valid,
    input wire [7:0] i_rx_data,
    output wire o_rx_ready,
    // byte stream to the link
    output wire o_tx_valid,
    output wire [7:0] o_tx_data,
    input wire i_tx_ready,
    // device state
    output reg [1:0] o_lock_state,
    output reg [1:0] o_remote_state,
    output reg [7:0] o_step_count,
    output reg o_steps_init,
    // APB slave
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    output wire o_pready,
    output reg [31:0] o_prdata,
    output reg o_pslverr
);

    // ****************************************
    // receive state machine
    // ****************************************
    localparam S_HDR = 3'h0;
    localparam S_DST = 3'h1;
    localparam S_SRC = 3'h2;
    localparam S_LEN = 3'h3;
    localparam S_CMD = 3'h4;
    localparam S_PAR = 3'h5;
    localparam S_SUM = 3'h6;
    localparam S_EXEC = 3'h7;

    reg [2:0] state_q;
    reg [7:0] sum_q;
    reg [7:0] len_q;
    reg [7:0] cmd_q;
    reg [2:0] pcnt_q;
    reg mine_q;
    reg [7:0] par_q [0:5];
    reg [7:0] err_q;
    reg [3:0] capsel_q;
    reg [16:0] cap_q [0:9];
    reg [1:0] rng_q [0:9];
    wire rx_take;
    wire tx_busy;
    wire [31:0] cap_w;
    wire [3:0] slot_w;
    wire [7:0] sum_next;

    // no new byte while a decision or a reply is pending
    assign o_rx_ready = (state_q != S_EXEC) && !tx_busy;
    assign rx_take = i_rx_valid && o_rx_ready;
    assign sum_next = sum_q + i_rx_data;

    // little end first: first parameter byte after the index is bit 7:0
    assign cap_w = {par_q[4], par_q[3], par_q[2], par_q[1]};
    assign slot_w = par_q[0][3:0] - 4'h1;

    // ****************************************
    // dispatch decode
    // ****************************************
    reg exec_ok;
    reg exec_reply;
    reg [7:0] reply_cmd;
    reg [7:0] reply_data;
    reg do_lock;
    reg do_remote;
    reg do_init;
    reg do_cap;

    // legality of the held frame and the answer it earns
    always @* begin
        exec_ok = 1'b0;
        reply_cmd = `CMD_ACK;
        reply_data = `ACK_DATA;
        do_lock = 1'b0;
        do_remote = 1'b0;
        do_init = 1'b0;
        do_cap = 1'b0;
        case (cmd_q)
            `CMD_LOCK_SET: begin
                do_lock = (len_q == `FRM_LEN_ONEPAR) && (par_q[0] <= `MODE_MAX);
                exec_ok = do_lock;
            end
            `CMD_REMOTE_SET: begin
                do_remote = (len_q == `FRM_LEN_ONEPAR) && (par_q[0] <= `MODE_MAX);
                exec_ok = do_remote;
            end
            `CMD_STEPS_INIT: begin
                do_init = (len_q == `FRM_LEN_NOPAR);
                exec_ok = do_init;
            end
            `CMD_CAP_SET: begin
                // out of range values are dropped with no reply
                do_cap = (len_q == `FRM_LEN_CAP)
                    && (par_q[0] >= `STEP_IDX_MIN) && (par_q[0] <= `STEP_IDX_MAX)
                    && (cap_w <= `CAP_MAX)
                    && (par_q[5] >= `RANGE_MIN) && (par_q[5] <= `RANGE_MAX);
                exec_ok = do_cap;
            end
            `CMD_LOCK_GET: begin
                exec_ok = (len_q == `FRM_LEN_NOPAR);
                reply_cmd = cmd_q;
                reply_data = {6'h00, o_lock_state};
            end
            `CMD_STEPS_GET: begin
                exec_ok = (len_q == `FRM_LEN_NOPAR);
                reply_cmd = cmd_q;
                reply_data = o_step_count;
            end
            `CMD_REMOTE_GET: begin
                exec_ok = (len_q == `FRM_LEN_NOPAR);
                reply_cmd = cmd_q;
                reply_data = {6'h00, o_remote_state};
            end
            default: begin
                exec_ok = 1'b0;
            end
        endcase
        exec_reply = (state_q == S_EXEC) && exec_ok;
    end

    // ****************************************
    // frame parser
    // ****************************************
    reg frame_err;

    // field walk; a bad length or checksum drops the frame quietly
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= S_HDR;
            sum_q <= 8'h00;
            len_q <= 8'h00;
            cmd_q <= 8'h00;
            pcnt_q <= 3'h0;
            mine_q <= 1'b0;
            frame_err <= 1'b0;
        end else begin
            frame_err <= 1'b0;
            case (state_q)
                S_HDR: begin
                    if (rx_take && (i_rx_data == `FRM_HEADER)) begin
                        state_q <= S_DST;
                        sum_q <= 8'h00;
                    end
                end
                S_DST: begin
                    if (rx_take) begin
                        mine_q <= (i_rx_data == `FRM_ADDR_OWN);
                        sum_q <= sum_next;
                        state_q <= S_SRC;
                    end
                end
                S_SRC: begin
                    if (rx_take) begin
                        sum_q <= sum_next;
                        state_q <= S_LEN;
                    end
                end
                S_LEN: begin
                    if (rx_take) begin
                        sum_q <= sum_next;
                        len_q <= i_rx_data;
                        pcnt_q <= 3'h0;
                        // more than six parameters cannot be held
                        if ((i_rx_data < `FRM_LEN_MIN) || (i_rx_data > `FRM_LEN_MAX)) begin
                            state_q <= S_HDR;
                            frame_err <= 1'b1;
                        end else begin
                            state_q <= S_CMD;
                        end
                    end
                end
                S_CMD: begin
                    if (rx_take) begin
                        sum_q <= sum_next;
                        cmd_q <= i_rx_data;
                        state_q <= (len_q == `FRM_LEN_NOPAR) ? S_SUM : S_PAR;
                    end
                end
                S_PAR: begin
                    if (rx_take) begin
                        sum_q <= sum_next;
                        pcnt_q <= pcnt_q + 3'h1;
                        if ({5'h00, pcnt_q} == len_q - 8'h02) begin
                            state_q <= S_SUM;
                        end
                    end
                end
                S_SUM: begin
                    if (rx_take) begin
                        if ((sum_next == 8'h00) && mine_q) begin
                            state_q <= S_EXEC;
                        end else begin
                            state_q <= S_HDR;
                            frame_err <= mine_q;
                        end
                    end
                end
                S_EXEC: begin
                    state_q <= S_HDR;
                    frame_err <= !exec_ok;
                end
                default: begin
                    state_q <= S_HDR;
                end
            endcase
        end
    end

    // parameter bytes kept in arrival order
    always @(posedge i_clock) begin
        if ((state_q == S_PAR) && rx_take) begin
            par_q[pcnt_q] <= i_rx_data;
        end
    end

    // ****************************************
    // device state
    // ****************************************
    wire apb_wr;
    assign apb_wr = i_psel && i_penable && i_pwrite;

    // lock, control and step count; a frame's init beats a software write
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_lock_state <= 2'h0;
            o_remote_state <= 2'h0;
            o_step_count <= `STEPS_INIT;
            o_steps_init <= 1'b0;
        end else begin
            o_steps_init <= exec_reply && do_init;
            if (exec_reply && do_lock) begin
                o_lock_state <= par_q[0][1:0];
            end
            if (exec_reply && do_remote) begin
                o_remote_state <= par_q[0][1:0];
            end
            if (exec_reply && do_init) begin
                o_step_count <= `STEPS_INIT;
            end else if (apb_wr && (i_paddr == `REG_STEPS)) begin
                o_step_count <= i_pwdata[7:0];
            end
        end
    end

    // per-step reference capacitance and range
    genvar g;
    generate
        for (g = 0; g < `STEP_COUNT; g = g + 1) begin : g_step
            always @(posedge i_clock or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    cap_q[g] <= `CAP_INIT;
                    rng_q[g] <= `RANGE_INIT;
                end else if (exec_reply && do_init) begin
                    cap_q[g] <= `CAP_INIT;
                    rng_q[g] <= `RANGE_INIT;
                end else if (exec_reply && do_cap && (slot_w == g)) begin
                    cap_q[g] <= cap_w[16:0];
                    rng_q[g] <= par_q[5][1:0];
                end
            end
        end
    endgenerate

    // dropped frame counter; a new error beats a clear
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            err_q <= 8'h00;
        end else if (frame_err) begin
            err_q <= err_q + `ERR_INC;
        end else if (apb_wr && (i_paddr == `REG_ERRCNT)) begin
            err_q <= 8'h00;
        end
    end

    // ****************************************
    // APB slave
    // ****************************************
    // read data and error are registered in setup, so access ends at once
    assign o_pready = 1'b1;

    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            capsel_q <= 4'h0;
        end else if (apb_wr && (i_paddr == `REG_CAPSEL)) begin
            capsel_q <= i_pwdata[3:0];
        end
    end

    // setup-phase decode of the addressed word
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_prdata <= 32'h00000000;
            o_pslverr <= 1'b0;
        end else if (i_psel && !i_penable) begin
            o_pslverr <= 1'b0;
            o_prdata <= 32'h00000000;
            case (i_paddr)
                `REG_STATUS: begin
                    o_prdata <= {26'h0000000, tx_busy, 1'b0, o_remote_state, o_lock_state};
                end
                `REG_STEPS: begin
                    o_prdata <= {24'h000000, o_step_count};
                end
                `REG_ERRCNT: begin
                    o_prdata <= {24'h000000, err_q};
                end
                `REG_CAPSEL: begin
                    o_prdata <= {28'h0000000, capsel_q};
                end
                `REG_CAPVAL: begin
                    // index past the last step reads zero
                    if (capsel_q < `STEP_COUNT) begin
                        o_prdata <= {6'h00, rng_q[capsel_q], 7'h00, cap_q[capsel_q]};
                    end
                end
                default: begin
                    o_pslverr <= 1'b1;
                end
            endcase
        end
    end

    // ****************************************
    // reply sender
    // ****************************************
    reply_frame_sender u_sender (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_start(exec_reply),
        .i_cmd(reply_cmd),
        .i_data(reply_data),
        .i_tx_ready(i_tx_ready),
        .o_tx_valid(o_tx_valid),
        .o_tx_data(o_tx_data),
        .o_busy(tx_busy)
    );

endmodule // remote_command_frame_handler

/* File: design/frame_handler_map.vh */
// constants for the remote command frame handler: frame codes, limits and register map
`ifndef FRAME_HANDLER_MAP_VH
`define FRAME_HANDLER_MAP_VH

// ****************************************
// frame fields
// ****************************************
`define FRM_HEADER 8'hAB
`define FRM_ADDR_OWN 8'h01
`define FRM_ADDR_HOST 8'h70
`define FRM_LEN_MIN 8'h01
`define FRM_LEN_MAX 8'h07
`define FRM_LEN_NOPAR 8'h01
`define FRM_LEN_ONEPAR 8'h02
`define FRM_LEN_CAP 8'h07
`define FRM_LEN_REPLY 8'h02
`define FRM_TX_LAST 3'h6

// ****************************************
// command codes
// ****************************************
`define CMD_ACK 8'h7F
`define ACK_DATA 8'h00
`define CMD_LOCK_SET 8'h2A
`define CMD_LOCK_GET 8'hAA
`define CMD_STEPS_INIT 8'h2C
`define CMD_STEPS_GET 8'hAD
`define CMD_REMOTE_SET 8'h2E
`define CMD_REMOTE_GET 8'hAE
`define CMD_CAP_SET 8'h2F

// ****************************************
// value limits
// ****************************************
`define MODE_MAX 8'h02
`define STEP_IDX_MIN 8'h01
`define STEP_IDX_MAX 8'h0A
`define STEP_COUNT 10
`define CAP_MAX 32'h0001D4C0
`define RANGE_MIN 8'h01
`define RANGE_MAX 8'h03
`define CAP_INIT 17'h00000
`define RANGE_INIT 2'h1
`define STEPS_INIT 8'h00

// ****************************************
// register map (byte addresses)
// ****************************************
`define REG_STATUS 12'h000
`define REG_STEPS 12'h004
`define REG_ERRCNT 12'h008
`define REG_CAPSEL 12'h00C
`define REG_CAPVAL 12'h010
`define ERR_INC 8'h01

`endif

/* File: design/reply_frame_sender.v */
// reply frame sender: serialises one seven-byte answer frame with its checksum
`timescale 1ns/1ns
`include "frame_handler_map.vh"

module reply_frame_sender (
    input wire i_clock,
    input wire i_rst_n,
    input wire i_start,
    input wire [7:0] i_cmd,
    input wire [7:0] i_data,
    input wire i_tx_ready,
    output wire o_tx_valid,
    output reg [7:0] o_tx_data,
    output wire o_busy
);

    reg busy_q;
    reg [2:0] idx_q;
    reg [7:0] cmd_q;
    reg [7:0] data_q;
    wire [7:0] sum_w;
    wire [7:0] next_w;

    // negated byte sum, header left out
    assign sum_w = 8'h00 - (`FRM_ADDR_HOST + `FRM_ADDR_OWN + `FRM_LEN_REPLY + cmd_q + data_q);

    // byte that follows the one on the port
    function [7:0] byte_at;
        input [2:0] idx;
        begin
            case (idx)
                3'h1: byte_at = `FRM_ADDR_HOST;
                3'h2: byte_at = `FRM_ADDR_OWN;
                3'h3: byte_at = `FRM_LEN_REPLY;
                3'h4: byte_at = cmd_q;
                3'h5: byte_at = data_q;
                3'h6: byte_at = sum_w;
                default: byte_at = `FRM_HEADER;
            endcase
        end
    endfunction

    assign next_w = byte_at(idx_q + 3'h1);
    assign o_tx_valid = busy_q;
    assign o_busy = busy_q;

    // frame walk; the data byte stays put while the sink stalls
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            busy_q <= 1'b0;
            idx_q <= 3'h0;
            cmd_q <= 8'h00;
            data_q <= 8'h00;
            o_tx_data <= 8'h00;
        end else if (i_start && !busy_q) begin
            busy_q <= 1'b1;
            idx_q <= 3'h0;
            cmd_q <= i_cmd;
            data_q <= i_data;
            o_tx_data <= `FRM_HEADER;
        end else if (busy_q && i_tx_ready) begin
            if (idx_q == `FRM_TX_LAST) begin
                busy_q <= 1'b0;
            end else begin
                idx_q <= idx_q + 3'h1;
                o_tx_data <= next_w;
            end
        end
    end

endmodule // reply_frame_sender

/* File: verification/frame_handler_props.sv */
// assertion checker for the remote command frame handler ports
`timescale 1ns/1ns
module frame_handler_props (
    input wire i_clock,
    input wire i_rst_n,
    input wire o_rx_ready,
    input wire o_tx_valid,
    input wire [7:0] o_tx_data,
    input wire i_tx_ready,
    input wire [1:0] o_lock_state,
    input wire [1:0] o_remote_state,
    input wire [7:0] o_step_count,
    input wire o_steps_init,
    input wire i_psel,
    input wire i_penable,
    input wire [11:0] i_paddr,
    input wire o_pslverr
);
    // ******
    // reply byte tracking
    // ******
    reg [2:0] idx_q;
    reg [7:0] sum_q;
    // position in the reply and running sum after the header
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            idx_q <= 3'h0;
            sum_q <= 8'h00;
        end else if (o_tx_valid && i_tx_ready) begin
            idx_q <= (idx_q == 3'h6) ? 3'h0 : idx_q + 3'h1;
            sum_q <= (idx_q == 3'h0) ? 8'h00 : sum_q + o_tx_data;
        end
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    property p_hdr; o_tx_valid && idx_q == 3'h0 |-> o_tx_data == 8'hAB; endproperty
    a_hdr: assert property (p_hdr) else $error("reply header wrong");
    property p_dst; o_tx_valid && idx_q == 3'h1 |-> o_tx_data == 8'h70; endproperty
    a_dst: assert property (p_dst) else $error("reply destination wrong");
    property p_src; o_tx_valid && idx_q == 3'h2 |-> o_tx_data == 8'h01; endproperty
    a_src: assert property (p_src) else $error("reply source wrong");
    property p_len; o_tx_valid && idx_q == 3'h3 |-> o_tx_data == 8'h02; endproperty
    a_len: assert property (p_len) else $error("reply length wrong");
    property p_sum; o_tx_valid && idx_q == 3'h6 |-> o_tx_data == 8'h00 - sum_q; endproperty
    a_sum: assert property (p_sum) else $error("reply checksum wrong");
    property p_hold; o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data); endproperty
    a_hold: assert property (p_hold) else $error("reply byte dropped");
    property p_block; o_tx_valid |-> !o_rx_ready; endproperty
    a_block: assert property (p_block) else $error("request taken during reply");
    property p_pulse; o_steps_init |=> !o_steps_init; endproperty
    a_pulse: assert property (p_pulse) else $error("init pulse too long");
    property p_zero; o_steps_init |-> ##[0:1] o_step_count == 8'h00; endproperty
    a_zero: assert property (p_zero) else $error("steps not cleared");
    property p_ack; $changed(o_lock_state) |-> ##[0:2] o_tx_valid; endproperty
    a_ack: assert property (p_ack) else $error("lock change without reply");
    property p_modes; o_lock_state != 2'h3 && o_remote_state != 2'h3; endproperty
    a_modes: assert property (p_modes) else $error("illegal mode value");
    property p_err; i_psel && i_penable && i_paddr == 12'h014 |-> o_pslverr; endproperty
    a_err: assert property (p_err) else $error("unmapped access not refused");
endmodule // frame_handler_props

/* File: verification/host_link_model.sv */
// host side link model: sends request frames and collects reply bytes
`timescale 1ns/1ns
module host_link_model (
    input wire i_clock,
    output reg o_rx_valid,
    output reg [7:0] o_rx_data,
    input wire i_rx_ready,
    input wire i_tx_valid,
    input wire [7:0] i_tx_data,
    output reg o_tx_ready
);
    // ******
    // reply sink and request source
    // ******
    reg slow = 1'b0;
    logic [7:0] got [$];
    initial begin
        o_rx_valid = 1'b0;
        o_rx_data = 8'h00;
        o_tx_ready = 1'b1;
    end
    // stalls every other cycle when slow, so reply bytes must be held
    always @(posedge i_clock) begin
        o_tx_ready <= slow ? ~o_tx_ready : 1'b1;
        if (i_tx_valid && o_tx_ready) begin
            got.push_back(i_tx_data);
        end
    end
    // one byte, held until the edge that takes it
    task put(input [7:0] b);
        o_rx_valid <= 1'b1;
        o_rx_data <= b;
        @(posedge i_clock);
        while (i_rx_ready !== 1'b1) @(posedge i_clock);
    endtask
    // whole frame; valid stays high between bytes
    task send(input [7:0] dst, input [7:0] cmd, input [2:0] np, input [47:0] par,
              input [7:0] bad);
        reg [7:0] s;
        integer i;
        s = 8'h00 - dst - 8'h70 - {5'h0, np} - 8'h01 - cmd;
        got.delete();
        put(8'hAB);
        put(dst);
        put(8'h70);
        put({5'h0, np} + 8'h01);
        put(cmd);
        for (i = 0; i < np; i++) begin
            put(par[8 * i +: 8]);
            s = s - par[8 * i +: 8];
        end
        put(s ^ bad);
        o_rx_valid <= 1'b0;
        o_rx_data <= ~(s ^ bad); // released line no longer shows the checksum
    endtask
endmodule // host_link_model

/* File: verification/remote_command_frame_handler_tb.sv */
// testbench for the remote command frame handler
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module remote_command_frame_handler_tb;
    typedef struct packed {logic [7:0] cmd; logic [2:0] np; logic [47:0] par;
        logic [7:0] code; logic [7:0] dat; logic [1:0] lk; logic [1:0] rm;} row_t;
    logic i_clock = 1'b0;
    // starts high so the fall at time zero reaches every reset process
    logic i_rst_n = 1'b1;
    logic i_psel, i_penable, i_pwrite, er, o_pready, o_pslverr, o_steps_init;
    logic [11:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, rd;
    logic [1:0] o_lock_state, o_remote_state;
    logic [7:0] o_step_count, i_rx_data, o_tx_data;
    wire i_rx_valid, o_rx_ready, o_tx_valid, i_tx_ready;
    integer miscompares = 0;
    integer n_checks = 0;
    integer n_init = 0;
    integer i;
    // ******
    // ordinary frames with their replies and states
    // ******
    row_t rows [0:13] = '{'{8'h2A, 3'h1, 48'h01, 8'h7F, 8'h00, 2'h1, 2'h0},
        '{8'hAA, 3'h0, 48'h0, 8'hAA, 8'h01, 2'h1, 2'h0},
        '{8'h2A, 3'h1, 48'h02, 8'h7F, 8'h00, 2'h2, 2'h0},
        '{8'hAA, 3'h0, 48'h0, 8'hAA, 8'h02, 2'h2, 2'h0},
        '{8'h2A, 3'h1, 48'h00, 8'h7F, 8'h00, 2'h0, 2'h0},
        '{8'hAA, 3'h0, 48'h0, 8'hAA, 8'h00, 2'h0, 2'h0},
        '{8'h2E, 3'h1, 48'h01, 8'h7F, 8'h00, 2'h0, 2'h1},
        '{8'hAE, 3'h0, 48'h0, 8'hAE, 8'h01, 2'h0, 2'h1},
        '{8'h2E, 3'h1, 48'h02, 8'h7F, 8'h00, 2'h0, 2'h2},
        '{8'hAE, 3'h0, 48'h0, 8'hAE, 8'h02, 2'h0, 2'h2},
        '{8'h2E, 3'h1, 48'h00, 8'h7F, 8'h00, 2'h0, 2'h0},
        '{8'hAD, 3'h0, 48'h0, 8'hAD, 8'h00, 2'h0, 2'h0},
        '{8'h2F, 3'h6, 48'h010000040001, 8'h7F, 8'h00, 2'h0, 2'h0},
        '{8'h2F, 3'h6, 48'h030001D4C00A, 8'h7F, 8'h00, 2'h0, 2'h0}};
    always #4 i_clock = ~i_clock;
    // init pulses seen by the bench
    always @(posedge i_clock) begin
        if (o_steps_init === 1'b1) begin
            n_init <= n_init + 1;
        end
    end
    remote_command_frame_handler u_remote_command_frame_handler (.i_clock(i_clock),
        .i_rst_n(i_rst_n), .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data),
        .o_rx_ready(o_rx_ready), .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data),
        .i_tx_ready(i_tx_ready), .o_lock_state(o_lock_state), .o_remote_state(o_remote_state),
        .o_step_count(o_step_count), .o_steps_init(o_steps_init), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr));
    host_link_model u_host_link_model (.i_clock(i_clock), .o_rx_valid(i_rx_valid),
        .o_rx_data(i_rx_data), .i_rx_ready(o_rx_ready), .i_tx_valid(o_tx_valid),
        .i_tx_data(o_tx_data), .o_tx_ready(i_tx_ready));
    // one transfer; request held until pready is seen high
    task apb(input w, input [11:0] a, input [31:0] d);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clock);
        i_penable <= 1'b1;
        @(posedge i_clock);
        while (o_pready !== 1'b1) @(posedge i_clock);
        rd = o_prdata;
        er = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_clock);
    endtask
    // one frame, then the reply or its absence
    task run(input [7:0] dst, input [7:0] cmd, input [2:0] np, input [47:0] par,
             input [7:0] bad, input [7:0] code, input [7:0] dat, input ok);
        reg [55:0] gv;
        integer k;
        u_host_link_model.send(dst, cmd, np, par, bad);
        for (k = 0; k < 60 && u_host_link_model.got.size() < 7; k++) @(posedge i_clock);
        gv = 56'h0;
        for (k = 0; k < 7 && ok; k++) gv = {gv[47:0], u_host_link_model.got[k]};
        if (ok) begin
            `CHK(gv, {16'hAB70, 16'h0102, code, dat, 8'h00 - 8'h73 - code - dat})
        end else begin
            `CHK(u_host_link_model.got.size(), 0)
        end
    endtask
    task summarize;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        miscompares++;
        summarize;
    end
    initial begin
        {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = 47'h0;
        i_rst_n <= 1'b0;
        repeat (8) @(posedge i_clock);
        i_rst_n <= 1'b1;
        @(posedge i_clock);
        `CHK({o_tx_valid, o_rx_ready, o_lock_state, o_remote_state}, 6'h10)
        apb(1'b0, 12'h010, 32'h0);
        `CHK(rd, 32'h01000000)
        apb(1'b0, 12'h014, 32'h0);
        `CHK({er, rd}, 33'h100000000)
        for (i = 0; i < 14; i++) begin
            u_host_link_model.slow = i[0];
            run(8'h01, rows[i].cmd, rows[i].np, rows[i].par, 8'h00, rows[i].code, rows[i].dat, 1);
            `CHK({o_lock_state, o_remote_state}, {rows[i].lk, rows[i].rm})
        end
        // hand-written: stored capacitance, refusals, step count
        apb(1'b1, 12'h00C, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        `CHK(rd, 32'h01000400)
        apb(1'b1, 12'h00C, 32'h9);
        apb(1'b0, 12'h010, 32'h0);
        `CHK(rd, 32'h0301D4C0)
        run(8'h01, 8'h2A, 3'h1, 48'h03, 8'h00, 8'h00, 8'h00, 0);
        run(8'h01, 8'h2F, 3'h6, 48'h010001D4C101, 8'h00, 8'h00, 8'h00, 0);
        run(8'h01, 8'h2F, 3'h6, 48'h01000004000B, 8'h00, 8'h00, 8'h00, 0);
        run(8'h01, 8'h2F, 3'h6, 48'h040000040001, 8'h00, 8'h00, 8'h00, 0);
        run(8'h01, 8'hAA, 3'h0, 48'h0, 8'h01, 8'h00, 8'h00, 0);
        run(8'h02, 8'hAA, 3'h0, 48'h0, 8'h00, 8'h00, 8'h00, 0);
        run(8'h01, 8'h2A, 3'h0, 48'h0, 8'h00, 8'h00, 8'h00, 0);
        run(8'h01, 8'h2E, 3'h1, 48'h03, 8'h00, 8'h00, 8'h00, 0);
        apb(1'b0, 12'h008, 32'h0);
        `CHK(rd, 32'h7)
        apb(1'b0, 12'h000, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b1, 12'h004, 32'h5);
        run(8'h01, 8'hAD, 3'h0, 48'h0, 8'h00, 8'hAD, 8'h05, 1);
        run(8'h01, 8'h2C, 3'h0, 48'h0, 8'h00, 8'h7F, 8'h00, 1);
        `CHK(n_init, 1)
        apb(1'b0, 12'h010, 32'h0);
        `CHK({o_step_count, rd}, 40'h0001000000)
        run(8'h01, 8'hAD, 3'h0, 48'h0, 8'h00, 8'hAD, 8'h00, 1);
        run(8'h01, 8'h2A, 3'h1, 48'h02, 8'h00, 8'h7F, 8'h00, 1);
        `CHK(o_lock_state, 2'h2)
        // reset in mid-run brings lock and step count back to idle values
        apb(1'b1, 12'h004, 32'h3);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clock);
        i_rst_n <= 1'b1;
        @(posedge i_clock);
        `CHK({o_tx_valid, o_rx_ready, o_lock_state, o_step_count}, 12'h400)
        summarize;
    end
endmodule // remote_command_frame_handler_tb
bind remote_command_frame_handler frame_handler_props u_frame_handler_props (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .o_rx_ready(o_rx_ready), .o_tx_valid(o_tx_valid),
    .o_tx_data(o_tx_data), .i_tx_ready(i_tx_ready), .o_lock_state(o_lock_state),
    .o_remote_state(o_remote_state), .o_step_count(o_step_count),
    .o_steps_init(o_steps_init), .i_psel(i_psel), .i_penable(i_penable),
    .i_paddr(i_paddr), .o_pslverr(o_pslverr));
